// File: hw/flash_register_command_decoder.sv
`timescale 1ns/1ps
module flash_register_command_decoder (
  // System
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Mode flags
  output logic             four_line_command_mode,
  output logic             long_addr_mode_bit,
  output logic             block_protect_mode,
  output logic             deep_power_down,
  output logic             suspend_req
);

  // Registers of the clock domain
  logic [7:0]  status_r;
  logic [7:0]  config_r;
  logic [7:0]  ext_r;
  logic [7:0]  burst_r;
  logic [31:0] boot_r;
  logic        quad_r;
  logic        long_r;
  logic        prot_r;
  logic        pd_r;
  logic        susp_r;
  logic [31:0] rdata_r;

  // Link domain state
  logic        active_r;
  logic [5:0]  cnt_r;
  logic [7:0]  op_r;
  logic [31:0] dat_r;
  logic [3:0]  out_r;
  logic [3:0]  oe_r;

  // ---------------- Link side, clocked by sclk ----------------
  // Chip select high ends the frame without needing an sclk edge
  wire link_clr = cs_n | ~rst_n;

  wire [5:0]  step     = quad_r ? 6'h04 : 6'h01;
  wire [5:0]  base_cnt = active_r ? cnt_r : 6'h00;
  wire [7:0]  base_op  = active_r ? op_r : 8'h00;
  wire [31:0] base_dat = active_r ? dat_r : 32'h0;
  wire        base_full = base_cnt >= flash_cmd_pkg::op_bits;
  wire [5:0]  cnt_sum  = base_cnt + step;
  wire [5:0]  cnt_nxt  = (base_cnt < flash_cmd_pkg::max_bits) ?
                         cnt_sum : base_cnt;
  // Opcode and data shift in MSB first, one or four lines
  wire [7:0]  op_nxt   = base_full ? base_op :
                         (quad_r ? {base_op[3:0], io_i} :
                                   {base_op[6:0], io_i[0]});
  wire [31:0] dat_nxt  = !base_full ? base_dat :
                         (quad_r ? {base_dat[27:0], io_i} :
                                   {base_dat[30:0], io_i[0]});

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      active_r <= 1'b0;
    end else begin
      active_r <= 1'b1;
    end
  end

  // Captured frame stays put after chip select rises
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 6'h00;
      op_r  <= 8'h00;
      dat_r <= 32'h0;
    end else begin
      cnt_r <= cnt_nxt;
      op_r  <= op_nxt;
      dat_r <= dat_nxt;
    end
  end

  wire op_full = cnt_r >= flash_cmd_pkg::op_bits;
  wire is_read = (op_r == flash_cmd_pkg::read_status_cmd) ||
                 (op_r == flash_cmd_pkg::read_config_cmd) ||
                 (op_r == flash_cmd_pkg::read_ext_addr_cmd) ||
                 (op_r == flash_cmd_pkg::read_boot_reg_cmd);
  wire rd_en   = active_r && op_full && !pd_r && is_read &&
                 flash_cmd_pkg::cmd_ok(op_r, quad_r);
  // Byte registers repeat every byte while clocked out
  wire [31:0] rd_word =
    (op_r == flash_cmd_pkg::read_status_cmd)   ? {4{status_r}} :
    (op_r == flash_cmd_pkg::read_config_cmd)   ? {4{config_r}} :
    (op_r == flash_cmd_pkg::read_ext_addr_cmd) ? {4{ext_r}} :
    boot_r;
  wire [5:0]  pos = cnt_r - flash_cmd_pkg::op_bits;
  wire [31:0] rd_sh = rd_word << pos[4:0];

  // Output changes on the falling edge, host samples on the rising
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      oe_r  <= 4'h0;
      out_r <= 4'h0;
    end else begin
      oe_r  <= rd_en ? (quad_r ? 4'hf : 4'h2) : 4'h0;
      out_r <= quad_r ? rd_sh[31:28] : {2'h0, rd_sh[31], 1'b0};
    end
  end

  assign io_o  = out_r;
  assign io_oe = oe_r & {4{~cs_n}};

  // ---------------- Register side, clocked by clk ----------------
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  // Frame end: link registers are quiet, read them once
  wire frame_end = cs_s2_r & ~cs_s3_r;
  wire [5:0] dbits  = cnt_r - flash_cmd_pkg::op_bits;
  wire [2:0] nbytes = dbits[5:3];
  wire whole  = op_full && (cnt_r[2:0] == 3'h0);
  wire legal  = pd_r ? (op_r == flash_cmd_pkg::power_up_cmd) :
                flash_cmd_pkg::cmd_ok(op_r, quad_r);
  wire go     = frame_end && whole && legal;

  wire hit_latch_set = go && (op_r == flash_cmd_pkg::set_write_latch_cmd);
  wire hit_latch_clr = go && (op_r == flash_cmd_pkg::clear_write_latch_cmd);
  wire hit_stat_wr   = go && (op_r == flash_cmd_pkg::write_status_config_cmd)
                   && (nbytes == 3'h1 || nbytes == 3'h2);
  wire hit_wear  = go && (op_r == flash_cmd_pkg::write_ext_addr_cmd)
                   && (nbytes == 3'h1);
  wire hit_prot  = go && (op_r == flash_cmd_pkg::protect_scheme_select_cmd);
  wire hit_quad_on = go && (op_r == flash_cmd_pkg::enter_four_line_cmd);
  wire hit_rqio  = go && (op_r == flash_cmd_pkg::exit_four_line_cmd);
  wire hit_en4   = go && (op_r == flash_cmd_pkg::enter_long_addr_cmd);
  wire hit_ex4   = go && (op_r == flash_cmd_pkg::exit_long_addr_cmd);
  wire hit_susp  = go &&
                   (op_r == flash_cmd_pkg::program_erase_pause_cmd_a ||
                    op_r == flash_cmd_pkg::program_erase_pause_cmd_b);
  wire hit_res   = go &&
                   (op_r == flash_cmd_pkg::program_erase_continue_cmd_a ||
                    op_r == flash_cmd_pkg::program_erase_continue_cmd_b);
  wire hit_sleep = go && (op_r == flash_cmd_pkg::power_down_cmd);
  wire hit_wake  = go && (op_r == flash_cmd_pkg::power_up_cmd);
  wire hit_burst = go && (op_r == flash_cmd_pkg::burst_length_cmd)
                   && (nbytes == 3'h1);
  wire hit_wfbr  = go && (op_r == flash_cmd_pkg::write_boot_reg_cmd)
                   && (nbytes == 3'h4);
  wire hit_efbr  = go && (op_r == flash_cmd_pkg::erase_boot_reg_cmd);

  // Software writes lose to a command finishing in the same cycle
  wire sw_status = reg_wr && (reg_addr == flash_cmd_pkg::addr_status);
  wire sw_config = reg_wr && (reg_addr == flash_cmd_pkg::addr_config);
  wire sw_ext    = reg_wr && (reg_addr == flash_cmd_pkg::addr_ext);
  wire sw_burst  = reg_wr && (reg_addr == flash_cmd_pkg::addr_burst);
  wire sw_boot   = reg_wr && (reg_addr == flash_cmd_pkg::addr_boot);

  wire [7:0] latch_mask = 8'h01 << flash_cmd_pkg::write_latch_bit;
  wire two_b = nbytes == 3'h2;

  wire [7:0] status_nxt =
    hit_latch_set ? (status_r | latch_mask) :
    hit_latch_clr ? (status_r & ~latch_mask) :
    hit_stat_wr   ? (two_b ? dat_r[15:8] : dat_r[7:0]) :
    sw_status ? reg_wdata[7:0] : status_r;
  wire [7:0] config_nxt =
    (hit_stat_wr && two_b) ? dat_r[7:0] :
    sw_config ? reg_wdata[7:0] : config_r;
  wire [7:0] ext_nxt =
    hit_wear ? dat_r[7:0] :
    sw_ext   ? reg_wdata[7:0] : ext_r;
  wire [7:0] burst_nxt =
    hit_burst ? dat_r[7:0] :
    sw_burst ? reg_wdata[7:0] : burst_r;
  wire [31:0] boot_nxt =
    hit_wfbr ? dat_r :
    hit_efbr ? flash_cmd_pkg::boot_rst :
    sw_boot  ? reg_wdata : boot_r;
  wire quad_nxt = hit_quad_on | (quad_r & ~hit_rqio);
  wire long_nxt = hit_en4 | (long_r & ~hit_ex4);
  wire prot_nxt = hit_prot | prot_r;
  wire pd_nxt   = hit_sleep | (pd_r & ~hit_wake);
  wire susp_nxt = hit_susp | (susp_r & ~hit_res);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= flash_cmd_pkg::status_rst;
      config_r <= flash_cmd_pkg::config_rst;
      ext_r    <= flash_cmd_pkg::ext_rst;
      burst_r  <= flash_cmd_pkg::burst_rst;
      boot_r   <= flash_cmd_pkg::boot_rst;
      quad_r   <= 1'b0;
      long_r   <= 1'b0;
      prot_r   <= 1'b0;
      pd_r     <= 1'b0;
      susp_r   <= 1'b0;
    end else begin
      status_r <= status_nxt;
      config_r <= config_nxt;
      ext_r    <= ext_nxt;
      burst_r  <= burst_nxt;
      boot_r   <= boot_nxt;
      quad_r   <= quad_nxt;
      long_r   <= long_nxt;
      prot_r   <= prot_nxt;
      pd_r     <= pd_nxt;
      susp_r   <= susp_nxt;
    end
  end

  // Register read port, data valid only in the cycle after the strobe
  wire [31:0] flags_word = {26'h0, burst_r == 8'h00, susp_r, pd_r,
                            prot_r, long_r, quad_r};
  wire [31:0] rd_mux =
    (reg_addr == flash_cmd_pkg::addr_status) ? {24'h0, status_r} :
    (reg_addr == flash_cmd_pkg::addr_config) ? {24'h0, config_r} :
    (reg_addr == flash_cmd_pkg::addr_ext)    ? {24'h0, ext_r} :
    (reg_addr == flash_cmd_pkg::addr_burst)  ? {24'h0, burst_r} :
    (reg_addr == flash_cmd_pkg::addr_boot)   ? boot_r :
    (reg_addr == flash_cmd_pkg::addr_flags)  ? flags_word : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata              = rdata_r;
  assign four_line_command_mode = quad_r;
  assign long_addr_mode_bit     = long_r;
  assign block_protect_mode     = prot_r;
  assign deep_power_down        = pd_r;
  assign suspend_req            = susp_r;

  // ---------------- Checks ----------------
  chk_latch_set: assert property (@(posedge clk) disable iff (!rst_n)
    hit_latch_set |=> status_r[flash_cmd_pkg::write_latch_bit])
    else $error("write latch not set");
  chk_latch_clear: assert property (@(posedge clk) disable iff (!rst_n)
    hit_latch_clr |=> !status_r[flash_cmd_pkg::write_latch_bit])
    else $error("write latch not cleared");
  chk_status_pair: assert property (@(posedge clk) disable iff (!rst_n)
    (hit_stat_wr && two_b) |=>
      (status_r == $past(dat_r[15:8]) && config_r == $past(dat_r[7:0])))
    else $error("status/config write wrong");
  chk_ext_load: assert property (@(posedge clk) disable iff (!rst_n)
    hit_wear |=> ext_r == $past(dat_r[7:0]))
    else $error("extended address not loaded");
  chk_quad_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && whole && !pd_r && quad_r &&
     op_r == flash_cmd_pkg::enter_four_line_cmd) |=> quad_r)
    else $error("four-line entry in wrong mode acted");
  chk_quad_exit: assert property (@(posedge clk) disable iff (!rst_n)
    hit_rqio |=> !quad_r ##1 !quad_r || $past(hit_quad_on))
    else $error("four-line exit failed");
  chk_long_exit: assert property (@(posedge clk) disable iff (!rst_n)
    hit_ex4 |=> !long_addr_mode_bit)
    else $error("long address flag not cleared");
  chk_pd_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (pd_r && !hit_wake) |=> pd_r && $stable(status_r) || $past(sw_status))
    else $error("power-down left without wake opcode");
  chk_boot_erase: assert property (@(posedge clk) disable iff (!rst_n)
    hit_efbr |=> boot_r == flash_cmd_pkg::boot_rst)
    else $error("boot register not erased");
  chk_bad_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && !legal && !reg_wr) |=>
      ($stable(quad_r) && $stable(ext_r) && $stable(boot_r) &&
       $stable(long_r) && $stable(susp_r)))
    else $error("illegal opcode changed state");

  cov_status_pair: cover property (@(posedge clk) disable iff (!rst_n)
    hit_stat_wr && two_b);
  cov_quad_loop: cover property (@(posedge clk) disable iff (!rst_n)
    hit_quad_on ##[1:1000] hit_rqio);
  cov_boot_write: cover property (@(posedge clk) disable iff (!rst_n)
    hit_wfbr);
  cov_power_cycle: cover property (@(posedge clk) disable iff (!rst_n)
    hit_sleep ##[1:1000] hit_wake);
  cov_quad_read: cover property (@(posedge clk) disable iff (!rst_n)
    io_oe == 4'hf);

  // Mode and flag updates
  chk_quad_enter: assert property (@(posedge clk) disable iff (!rst_n)
    hit_quad_on |=> four_line_command_mode)
    else $error("four-line entry failed");
  chk_exit_single: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && !quad_r &&
     op_r == flash_cmd_pkg::exit_four_line_cmd) |=> !quad_r)
    else $error("four-line exit acted in single-line mode");
  chk_long_enter: assert property (@(posedge clk) disable iff (!rst_n)
    hit_en4 |=> long_addr_mode_bit)
    else $error("long address flag not set");
  chk_protect_set: assert property (@(posedge clk) disable iff (!rst_n)
    hit_prot |=> block_protect_mode)
    else $error("block protection not selected");
  chk_susp_set: assert property (@(posedge clk) disable iff (!rst_n)
    hit_susp |=> suspend_req)
    else $error("suspend not raised");
  chk_susp_clear: assert property (@(posedge clk) disable iff (!rst_n)
    hit_res |=> !suspend_req)
    else $error("suspend not cleared");
  chk_sleep_enter: assert property (@(posedge clk) disable iff (!rst_n)
    hit_sleep |=> deep_power_down)
    else $error("power-down not entered");
  chk_wake: assert property (@(posedge clk) disable iff (!rst_n)
    hit_wake |=> !deep_power_down)
    else $error("power-down not left");
  chk_sleep_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && pd_r && op_r != flash_cmd_pkg::power_up_cmd && !reg_wr)
      |=> ($stable(ext_r) && $stable(quad_r) && $stable(boot_r)))
    else $error("command acted during power-down");

  // Register loads from the link
  chk_status_one: assert property (@(posedge clk) disable iff (!rst_n)
    (hit_stat_wr && !two_b) |=> (status_r == $past(dat_r[7:0])))
    else $error("single status byte not stored");
  chk_burst_load: assert property (@(posedge clk) disable iff (!rst_n)
    hit_burst |=> (burst_r == $past(dat_r[7:0])))
    else $error("burst length not stored");
  chk_boot_write: assert property (@(posedge clk) disable iff (!rst_n)
    hit_wfbr |=> (boot_r == $past(dat_r)))
    else $error("boot register not written");
  chk_count_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && op_r == flash_cmd_pkg::write_ext_addr_cmd &&
     nbytes != 3'h1 && !reg_wr) |=> $stable(ext_r))
    else $error("extended address loaded with wrong length");
  chk_quad_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && quad_r && op_r == flash_cmd_pkg::write_boot_reg_cmd &&
     !reg_wr) |=> $stable(boot_r))
    else $error("boot register written in four-line mode");

  // Data line drive and register port
  chk_oe_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_s2_r && cs_n) |-> (oe_r == 4'h0))
    else $error("data lines driven while deselected");
  chk_oe_width: assert property (@(posedge clk) disable iff (!rst_n)
    (io_oe != 4'h0) |-> (io_oe == (quad_r ? 4'hf : 4'h2)))
    else $error("wrong data lines driven");
  chk_status_line: assert property (@(posedge clk) disable iff (!rst_n)
    (io_oe == 4'h2 && op_r == flash_cmd_pkg::read_status_cmd &&
     cnt_r == flash_cmd_pkg::op_bits) |-> (io_o[1] == status_r[7]))
    else $error("status top bit not driven");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == 32'h0))
    else $error("read data outside read cycle");
  chk_rdata_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr > flash_cmd_pkg::addr_flags) |=> (reg_rdata == 32'h0))
    else $error("unmapped read not zero");
  chk_flags_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == flash_cmd_pkg::addr_flags) |=>
      (reg_rdata[4:0] == $past({susp_r, pd_r, prot_r, long_r, quad_r})))
    else $error("flags word wrong");
  chk_boot_port: assert property (@(posedge clk) disable iff (!rst_n)
    (sw_boot && !hit_wfbr && !hit_efbr) |=> (boot_r == $past(reg_wdata)))
    else $error("software boot write lost");

endmodule : flash_register_command_decoder

// File: inc/flash_cmd_pkg.sv
// How it works
// - Opcode 06 in either mode sets the write latch bit.
// - Opcode 04 in either mode clears the write latch bit.
// - After opcode 05 the status register is driven onto the data lines.
// - After opcode 15 the configuration register is driven out.
// - Opcode 01 with one or two bytes stores status, then configuration.
// - C8 returns extended address; C5 with exactly one byte loads it.
// - Opcode 68, single-line only, selects individual block protection.
// - Opcode 35, single-line only, enters four-line command mode.
// - Opcode F5, four-line only, returns to single-line mode.
// - B7 enters four-byte address mode; E9 leaves it, clearing the flag.
// - B0 or 75 suspends, 30 or 7A resumes, in both modes.
// - Opcode B9 in either mode enters deep power-down.
// - Opcode AB in either mode leaves deep power-down.
// - Opcode C0 in either mode sets the wrap burst length.
// - Single-line only: 16 reads boot register, 17 writes four bytes, 18 erases.
package flash_cmd_pkg;
  localparam logic [7:0] set_write_latch_cmd        = 8'h06;
  localparam logic [7:0] clear_write_latch_cmd      = 8'h04;
  localparam logic [7:0] read_status_cmd            = 8'h05;
  localparam logic [7:0] read_config_cmd            = 8'h15;
  localparam logic [7:0] write_status_config_cmd    = 8'h01;
  localparam logic [7:0] read_ext_addr_cmd          = 8'hc8;
  localparam logic [7:0] write_ext_addr_cmd         = 8'hc5;
  localparam logic [7:0] protect_scheme_select_cmd  = 8'h68;
  localparam logic [7:0] enter_four_line_cmd        = 8'h35;
  localparam logic [7:0] exit_four_line_cmd         = 8'hf5;
  localparam logic [7:0] enter_long_addr_cmd        = 8'hb7;
  localparam logic [7:0] exit_long_addr_cmd         = 8'he9;
  localparam logic [7:0] program_erase_pause_cmd_a  = 8'hb0;
  localparam logic [7:0] program_erase_pause_cmd_b  = 8'h75;
  localparam logic [7:0] program_erase_continue_cmd_a = 8'h30;
  localparam logic [7:0] program_erase_continue_cmd_b = 8'h7a;
  localparam logic [7:0] power_down_cmd             = 8'hb9;
  localparam logic [7:0] power_up_cmd               = 8'hab;
  localparam logic [7:0] burst_length_cmd           = 8'hc0;
  localparam logic [7:0] read_boot_reg_cmd          = 8'h16;
  localparam logic [7:0] write_boot_reg_cmd         = 8'h17;
  localparam logic [7:0] erase_boot_reg_cmd         = 8'h18;

  localparam logic [3:0] addr_status = 4'h0;
  localparam logic [3:0] addr_config = 4'h1;
  localparam logic [3:0] addr_ext    = 4'h2;
  localparam logic [3:0] addr_burst  = 4'h3;
  localparam logic [3:0] addr_boot   = 4'h4;
  localparam logic [3:0] addr_flags  = 4'h5;

  localparam int write_latch_bit = 1;
  localparam logic [7:0]  status_rst = 8'h00;
  localparam logic [7:0]  config_rst = 8'h00;
  localparam logic [7:0]  ext_rst    = 8'h00;
  localparam logic [7:0]  burst_rst  = 8'h00;
  localparam logic [31:0] boot_rst   = 32'hffffffff;
  localparam logic [5:0]  op_bits    = 6'h08;
  localparam logic [5:0]  max_bits   = 6'h28;

  function automatic logic cmd_ok(input logic [7:0] op,
                                  input logic       quad);
    unique case (op)
      protect_scheme_select_cmd, enter_four_line_cmd, read_boot_reg_cmd,
      write_boot_reg_cmd, erase_boot_reg_cmd:
        cmd_ok = !quad;
      exit_four_line_cmd:
        cmd_ok = quad;
      set_write_latch_cmd, clear_write_latch_cmd, read_status_cmd,
      read_config_cmd, write_status_config_cmd, read_ext_addr_cmd,
      write_ext_addr_cmd, enter_long_addr_cmd, exit_long_addr_cmd,
      program_erase_pause_cmd_a, program_erase_pause_cmd_b,
      program_erase_continue_cmd_a, program_erase_continue_cmd_b,
      power_down_cmd, power_up_cmd, burst_length_cmd:
        cmd_ok = 1'b1;
      default:
        cmd_ok = 1'b0;
    endcase
  endfunction : cmd_ok
endpackage : flash_cmd_pkg

// File: tb/flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model (
  // Link to device
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] io_i,
  input  wire logic [3:0] io_o,
  input  wire logic [3:0] io_oe
);
  logic [3:0] host_d;

  // Shared lines: the device wins wherever it drives
  assign io_i = (io_oe & io_o) | (~io_oe & host_d);

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_d = 4'h5;
  end

  // One frame: opcode, nwr data bytes from wd top down, then nrd bytes read
  task automatic xfer(input logic [7:0] op, input logic quad, input int nwr,
                      input logic [31:0] wd, input int nrd,
                      output logic [31:0] rd);
    logic [39:0] sh;
    int          i;
    sh = {op, wd};
    rd = 32'h0;
    cs_n = 1'b0;
    #32;
    for (i = 0; i < 8 + 8 * nwr; i += (quad ? 4 : 1)) begin
      host_d = quad ? sh[39:36] : {~host_d[3:1], sh[39]};
      sh = sh << (quad ? 4 : 1);
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    for (i = 0; i < 8 * nrd; i += (quad ? 4 : 1)) begin
      host_d = ~host_d;
      #32;
      rd = quad ? {rd[27:0], io_i} : {rd[30:0], io_i[1]};
      sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    host_d = ~host_d;
    #100;
  endtask : xfer
endmodule : flash_host_model

// File: tb/flash_register_command_decoder_tb.sv
`timescale 1ns/1ps
module flash_register_command_decoder_tb;
  logic        clk, rst_n, sclk, cs_n, reg_wr, reg_rd, rd_d;
  logic [3:0]  io_i, io_o, io_oe, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, v, bt;
  logic        quad, lad, bpm, dpd, susp;
  logic [7:0]  st, cf, ex, bl;
  logic [31:0] expq[$];
  int          n_mismatch, n_checks, cyc, i;
  integer      seed;

  flash_register_command_decoder flash_register_command_decoder_inst (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_i(io_i),
    .io_o(io_o), .io_oe(io_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .four_line_command_mode(quad), .long_addr_mode_bit(lad),
    .block_protect_mode(bpm), .deep_power_down(dpd), .suspend_req(susp));

  flash_host_model flash_host_model_inst (
    .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rreg

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wreg

  task automatic cmd(input logic [7:0] op, input logic q, input int n,
                     input logic [31:0] d);
    flash_host_model_inst.xfer(op, q, n, d, 0, rd);
  endtask : cmd

  // Read results, one cycle after each read strobe
  always @(posedge clk) begin
    if (rd_d && expq.size() > 0) check(reg_rdata, expq.pop_front());
    rd_d <= reg_rd;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    seed = 32'h2cbf;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    st = flash_cmd_pkg::status_rst;
    cf = flash_cmd_pkg::config_rst;
    rreg(4'h0, {24'h0, st});
    rreg(4'h1, {24'h0, cf});
    rreg(4'h2, {24'h0, flash_cmd_pkg::ext_rst});
    rreg(4'h3, {24'h0, flash_cmd_pkg::burst_rst});
    rreg(4'h4, flash_cmd_pkg::boot_rst);
    rreg(4'h5, 32'h20);
    rreg(4'h6, 32'h0);
    cmd(flash_cmd_pkg::set_write_latch_cmd, 1'b0, 0, 32'h0);
    rreg(4'h0, 32'h1 << flash_cmd_pkg::write_latch_bit);
    cmd(flash_cmd_pkg::clear_write_latch_cmd, 1'b0, 0, 32'h0);
    rreg(4'h0, 32'h0);
    v = $random(seed);
    cmd(flash_cmd_pkg::write_status_config_cmd, 1'b0, 1, v);
    st = v[31:24];
    rreg(4'h0, {24'h0, st});
    v = $random(seed);
    cmd(flash_cmd_pkg::write_status_config_cmd, 1'b0, 2, v);
    st = v[31:24];
    cf = v[23:16];
    cmd(flash_cmd_pkg::write_status_config_cmd, 1'b0, 3, ~v);
    rreg(4'h0, {24'h0, st});
    rreg(4'h1, {24'h0, cf});
    flash_host_model_inst.xfer(flash_cmd_pkg::read_status_cmd, 1'b0, 0, 0, 2, rd);
    check(rd, {16'h0, st, st});
    flash_host_model_inst.xfer(flash_cmd_pkg::read_config_cmd, 1'b0, 0, 0, 1, rd);
    check(rd, {24'h0, cf});
    v = $random(seed);
    ex = v[31:24];
    cmd(flash_cmd_pkg::write_ext_addr_cmd, 1'b0, 1, v);
    cmd(flash_cmd_pkg::write_ext_addr_cmd, 1'b0, 2, ~v);
    rreg(4'h2, {24'h0, ex});
    flash_host_model_inst.xfer(flash_cmd_pkg::read_ext_addr_cmd, 1'b0, 0, 0, 1, rd);
    check(rd, {24'h0, ex});
    cmd(flash_cmd_pkg::enter_long_addr_cmd, 1'b0, 0, 32'h0);
    check({31'h0, lad}, 32'h1);
    cmd(flash_cmd_pkg::exit_long_addr_cmd, 1'b0, 0, 32'h0);
    check({31'h0, lad}, 32'h0);
    for (i = 0; i < 2; i++) begin
      cmd(i ? flash_cmd_pkg::program_erase_pause_cmd_b
            : flash_cmd_pkg::program_erase_pause_cmd_a, 1'b0, 0, 32'h0);
      check({31'h0, susp}, 32'h1);
      cmd(i ? flash_cmd_pkg::program_erase_continue_cmd_b
            : flash_cmd_pkg::program_erase_continue_cmd_a, 1'b0, 0, 32'h0);
      check({31'h0, susp}, 32'h0);
    end
    v = $random(seed);
    bl = v[31:24];
    cmd(flash_cmd_pkg::burst_length_cmd, 1'b0, 1, v);
    rreg(4'h3, {24'h0, bl});
    bt = $random(seed);
    cmd(flash_cmd_pkg::write_boot_reg_cmd, 1'b0, 4, bt);
    rreg(4'h4, bt);
    flash_host_model_inst.xfer(flash_cmd_pkg::read_boot_reg_cmd, 1'b0, 0, 0, 4, rd);
    check(rd, bt);
    cmd(flash_cmd_pkg::erase_boot_reg_cmd, 1'b0, 0, 32'h0);
    rreg(4'h4, 32'hffffffff);
    cmd(flash_cmd_pkg::protect_scheme_select_cmd, 1'b0, 0, 32'h0);
    check({31'h0, bpm}, 32'h1);
    cmd(flash_cmd_pkg::power_down_cmd, 1'b0, 0, 32'h0);
    check({31'h0, dpd}, 32'h1);
    cmd(flash_cmd_pkg::write_ext_addr_cmd, 1'b0, 1, ~{ex, 24'h0});
    rreg(4'h2, {24'h0, ex});
    cmd(flash_cmd_pkg::power_up_cmd, 1'b0, 0, 32'h0);
    check({31'h0, dpd}, 32'h0);
    cmd(flash_cmd_pkg::exit_four_line_cmd, 1'b0, 0, 32'h0);
    check({31'h0, quad}, 32'h0);
    cmd(flash_cmd_pkg::enter_four_line_cmd, 1'b0, 0, 32'h0);
    check({31'h0, quad}, 32'h1);
    cmd(flash_cmd_pkg::enter_four_line_cmd, 1'b1, 0, 32'h0);
    check({31'h0, quad}, 32'h1);
    cmd(flash_cmd_pkg::write_boot_reg_cmd, 1'b1, 4, bt);
    rreg(4'h4, 32'hffffffff);
    cmd(flash_cmd_pkg::clear_write_latch_cmd, 1'b1, 0, 32'h0);
    st[flash_cmd_pkg::write_latch_bit] = 1'b0;
    flash_host_model_inst.xfer(flash_cmd_pkg::read_status_cmd, 1'b1, 0, 0, 1, rd);
    check(rd, {24'h0, st});
    cmd(flash_cmd_pkg::set_write_latch_cmd, 1'b1, 0, 32'h0);
    st[flash_cmd_pkg::write_latch_bit] = 1'b1;
    rreg(4'h0, {24'h0, st});
    cmd(flash_cmd_pkg::exit_four_line_cmd, 1'b1, 0, 32'h0);
    check({31'h0, quad}, 32'h0);
    v = $random(seed);
    wreg(4'h0, v);
    wreg(4'h5, 32'h0);
    rreg(4'h0, {24'h0, v[7:0]});
    rreg(4'h5, {26'h0, bl == 8'h00, 5'h04});
    wreg(4'h4, v);
    rreg(4'h4, v);
    check({28'h0, io_oe}, 32'h0);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule : flash_register_command_decoder_tb
